// >>> shared/fsf_pkg.sv
// constants and carriers for the flash status flag bank
// assumes one clock domain; flag sources are device logic on that clock
package fsf_pkg;

    // register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int WORD_W = 16;
    localparam int IRQ_W  = 3;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CLEAR_STAT = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_PROG_ERR   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT   = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQ_EN     = 8'h14;

    // status word fields
    localparam int BIT_RESV_HI_LSB = 10;
    localparam int BIT_RESV_HI_MSB = 15;
    localparam int BIT_RESV_LO     = 9;
    localparam int BIT_CRC_SUSP    = 8;
    localparam int BIT_READY_BUSY  = 7;
    localparam int BIT_ERASE_SUSP  = 6;
    localparam int BIT_ERASE_ERR   = 5;
    localparam int BIT_CLEAR_GO    = 0;

    // reserved defaults and reset values
    localparam logic [5:0] RESV_HI_DEFAULT = 6'h3f;
    localparam logic       RESV_LO_DEFAULT = 1'h0;
    localparam logic [WORD_W-1:0] STATUS_RESET = 16'hfc00;

    // interrupt event bit positions
    localparam int IRQ_ERASE_ERR = 0;
    localparam int IRQ_PROG_ERR  = 1;
    localparam int IRQ_READY     = 2;

    // level state from the embedded operation controller
    typedef struct packed {
        logic op_busy;
        logic erase_susp;
        logic crc_susp;
    } fsf_dev_state_t;

    // one-cycle event pulses from the controller and link decoder
    typedef struct packed {
        logic erase_fail;
        logic erase_prot;
        logic prog_fail;
        logic clear_status;
        logic soft_reset;
    } fsf_dev_event_t;

endpackage : fsf_pkg

// >>> hw/fsf_status_bank.sv
// status flag bank of the flash device, x8 interface view
// assumes state and event inputs come from logic on MCLK, so no sync
module fsf_status_bank
    import fsf_pkg::*;
(
    // clock and reset
    input  wire logic                   MCLK,
    input  wire logic                   RESETN,
    // register port
    input  wire logic [fsf_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [fsf_pkg::DATA_W-1:0] WDATA,
    input  wire logic                   WR,
    input  wire logic                   RD,
    output logic      [fsf_pkg::DATA_W-1:0] RDATA,
    // device internal state
    input  wire fsf_pkg::fsf_dev_state_t DEV_STATE,
    input  wire fsf_pkg::fsf_dev_event_t DEV_EVENT,
    // status and interrupt
    output logic      [fsf_pkg::WORD_W-1:0] STATUS_WORD,
    output logic                        IRQ
);
    import fsf_pkg::*;

    logic                erase_err_r;
    logic                erase_err_nxt;
    logic                prog_err_r;
    logic                prog_err_nxt;
    logic [WORD_W-1:0]   status_r;
    logic [WORD_W-1:0]   status_nxt;
    logic [IRQ_W-1:0]    irq_stat_r;
    logic [IRQ_W-1:0]    irq_stat_nxt;
    logic [IRQ_W-1:0]    irq_en_r;
    logic [IRQ_W-1:0]    irq_en_nxt;
    logic                irq_r;
    logic                irq_nxt;
    logic [DATA_W-1:0]   rdata_r;
    logic [DATA_W-1:0]   rdata_nxt;
    logic                clr_req;
    logic                busy_now;
    logic [IRQ_W-1:0]    irq_evt;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // clear from the link transaction or from software, plus soft reset
    assign clr_req = DEV_EVENT.clear_status | DEV_EVENT.soft_reset
                   | (WR & hit(ADDR, OFS_CLEAR_STAT) & WDATA[BIT_CLEAR_GO]);

    // error flags: set beats clear so a failure in the clear cycle stays
    always_comb begin
        erase_err_nxt = erase_err_r;
        if (clr_req) begin
            erase_err_nxt = 1'b0;
        end
        if (DEV_EVENT.erase_fail | DEV_EVENT.erase_prot) begin
            erase_err_nxt = 1'b1;
        end
        prog_err_nxt = prog_err_r;
        if (clr_req) begin
            prog_err_nxt = 1'b0;
        end
        if (DEV_EVENT.prog_fail) begin
            prog_err_nxt = 1'b1;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            erase_err_r <= 1'b0;
            prog_err_r  <= 1'b0;
        end else begin
            erase_err_r <= erase_err_nxt;
            prog_err_r  <= prog_err_nxt;
        end
    end

    // status word; writes to it are ignored, reserved bits fixed
    always_comb begin
        busy_now = DEV_STATE.op_busy | erase_err_nxt | prog_err_nxt;
        status_nxt = '0;
        status_nxt[BIT_RESV_HI_MSB:BIT_RESV_HI_LSB] = RESV_HI_DEFAULT;
        status_nxt[BIT_RESV_LO]    = RESV_LO_DEFAULT;
        status_nxt[BIT_CRC_SUSP]   = DEV_STATE.crc_susp;
        status_nxt[BIT_READY_BUSY] = busy_now;
        status_nxt[BIT_ERASE_SUSP] = DEV_STATE.erase_susp;
        status_nxt[BIT_ERASE_ERR]  = erase_err_nxt;
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            status_r <= STATUS_RESET;
        end else begin
            status_r <= status_nxt;
        end
    end

    // interrupts: sticky, set wins over write-one clear
    always_comb begin
        irq_evt = '0;
        irq_evt[IRQ_ERASE_ERR] = erase_err_nxt & ~erase_err_r;
        irq_evt[IRQ_PROG_ERR]  = prog_err_nxt & ~prog_err_r;
        irq_evt[IRQ_READY]     = status_r[BIT_READY_BUSY] & ~busy_now;
        irq_stat_nxt = irq_stat_r;
        if (WR && hit(ADDR, OFS_IRQ_CLEAR)) begin
            irq_stat_nxt = irq_stat_r & ~WDATA[IRQ_W-1:0];
        end
        irq_stat_nxt = irq_stat_nxt | irq_evt;
        irq_en_nxt = irq_en_r;
        if (WR && hit(ADDR, OFS_IRQ_EN)) begin
            irq_en_nxt = WDATA[IRQ_W-1:0];
        end
        irq_nxt = |(irq_stat_nxt & irq_en_nxt);
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            irq_stat_r <= '0;
            irq_en_r   <= '0;
            irq_r      <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_en_r   <= irq_en_nxt;
            irq_r      <= irq_nxt;
        end
    end

    // read data from registered snapshot only, never live inputs
    always_comb begin
        rdata_nxt = '0;
        if (RD) begin
            case (ADDR)
                OFS_STATUS: begin
                    rdata_nxt[WORD_W-1:0] = status_r;
                end
                OFS_PROG_ERR: begin
                    rdata_nxt[0] = prog_err_r;
                end
                OFS_IRQ_STAT: begin
                    rdata_nxt[IRQ_W-1:0] = irq_stat_r;
                end
                OFS_IRQ_EN: begin
                    rdata_nxt[IRQ_W-1:0] = irq_en_r;
                end
                default: begin
                    rdata_nxt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign RDATA       = rdata_r;
    assign STATUS_WORD = status_r;
    assign IRQ         = irq_r;

    // checks
    property p_crc_susp;
        @(posedge MCLK) disable iff (!RESETN)
        ##1 STATUS_WORD[BIT_CRC_SUSP] == $past(DEV_STATE.crc_susp);
    endproperty
    a_crc_susp: assert property (p_crc_susp)
        else $error("check suspend bit does not follow source");

    property p_busy;
        @(posedge MCLK) disable iff (!RESETN)
        DEV_STATE.op_busy |=> STATUS_WORD[BIT_READY_BUSY];
    endproperty
    a_busy: assert property (p_busy)
        else $error("busy not shown during operation");

    property p_ready;
        @(posedge MCLK) disable iff (!RESETN)
        (!DEV_STATE.op_busy && !erase_err_nxt && !prog_err_nxt)
            |=> !STATUS_WORD[BIT_READY_BUSY];
    endproperty
    a_ready: assert property (p_ready)
        else $error("ready not shown while idle");

    property p_err_forces_busy;
        @(posedge MCLK) disable iff (!RESETN)
        (erase_err_r || prog_err_r) |-> STATUS_WORD[BIT_READY_BUSY];
    endproperty
    a_err_forces_busy: assert property (p_err_forces_busy)
        else $error("error flag set but device reads ready");

    property p_erase_susp;
        @(posedge MCLK) disable iff (!RESETN)
        ##1 STATUS_WORD[BIT_ERASE_SUSP] == $past(DEV_STATE.erase_susp);
    endproperty
    a_erase_susp: assert property (p_erase_susp)
        else $error("erase suspend bit does not follow source");

    property p_erase_set;
        @(posedge MCLK) disable iff (!RESETN)
        (DEV_EVENT.erase_fail || DEV_EVENT.erase_prot)
            |=> STATUS_WORD[BIT_ERASE_ERR] && STATUS_WORD[BIT_READY_BUSY];
    endproperty
    a_erase_set: assert property (p_erase_set)
        else $error("erase failure did not set error flag");

    property p_erase_hold;
        @(posedge MCLK) disable iff (!RESETN)
        (STATUS_WORD[BIT_ERASE_ERR] && !clr_req)
            |=> STATUS_WORD[BIT_ERASE_ERR];
    endproperty
    a_erase_hold: assert property (p_erase_hold)
        else $error("erase error cleared without clear or reset");

    property p_erase_clear;
        @(posedge MCLK) disable iff (!RESETN)
        (clr_req && !DEV_EVENT.erase_fail && !DEV_EVENT.erase_prot)
            |=> !STATUS_WORD[BIT_ERASE_ERR];
    endproperty
    a_erase_clear: assert property (p_erase_clear)
        else $error("clear did not drop erase error");

    property p_reserved;
        @(posedge MCLK) disable iff (!RESETN)
        STATUS_WORD[BIT_RESV_HI_MSB:BIT_RESV_LO]
            == {RESV_HI_DEFAULT, RESV_LO_DEFAULT};
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved status bits left their defaults");

    property p_read_word;
        @(posedge MCLK) disable iff (!RESETN)
        (RD && ADDR == OFS_STATUS)
            |=> RDATA[WORD_W-1:0] == $past(STATUS_WORD);
    endproperty
    a_read_word: assert property (p_read_word)
        else $error("status read not one registered snapshot");

    // flag may only rise on a device event, never from the host
    property p_erase_rise;
        @(posedge MCLK) disable iff (!RESETN)
        (!STATUS_WORD[BIT_ERASE_ERR] && !DEV_EVENT.erase_fail
            && !DEV_EVENT.erase_prot) |=> !STATUS_WORD[BIT_ERASE_ERR];
    endproperty
    a_erase_rise: assert property (p_erase_rise)
        else $error("erase error rose without a device event");

    property p_erase_prot;
        @(posedge MCLK) disable iff (!RESETN)
        DEV_EVENT.erase_prot |=> STATUS_WORD[BIT_ERASE_ERR];
    endproperty
    a_erase_prot: assert property (p_erase_prot)
        else $error("protected erase did not set error flag");

    // failure in the clear cycle must survive the clear
    property p_set_wins;
        @(posedge MCLK) disable iff (!RESETN)
        (clr_req && (DEV_EVENT.erase_fail || DEV_EVENT.erase_prot))
            |=> STATUS_WORD[BIT_ERASE_ERR];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("clear beat a failure in the same cycle");

    property p_err_keeps_busy;
        @(posedge MCLK) disable iff (!RESETN)
        (STATUS_WORD[BIT_ERASE_ERR] && !clr_req)
            |=> STATUS_WORD[BIT_READY_BUSY];
    endproperty
    a_err_keeps_busy: assert property (p_err_keeps_busy)
        else $error("ready shown while erase error still set");

    property p_prog_busy;
        @(posedge MCLK) disable iff (!RESETN)
        DEV_EVENT.prog_fail |=> STATUS_WORD[BIT_READY_BUSY];
    endproperty
    a_prog_busy: assert property (p_prog_busy)
        else $error("program failure did not force busy");

    property p_ready_clean;
        @(posedge MCLK) disable iff (!RESETN)
        !STATUS_WORD[BIT_READY_BUSY]
            |-> !STATUS_WORD[BIT_ERASE_ERR] && !prog_err_r;
    endproperty
    a_ready_clean: assert property (p_ready_clean)
        else $error("ready shown with an error flag set");

    // read data only in the cycle after a read strobe
    property p_rdata_idle;
        @(posedge MCLK) disable iff (!RESETN)
        !RD |=> RDATA == '0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data present without a read");

    property p_rdata_upper;
        @(posedge MCLK) disable iff (!RESETN)
        RDATA[DATA_W-1:WORD_W] == '0;
    endproperty
    a_rdata_upper: assert property (p_rdata_upper)
        else $error("read data upper half not zero");

endmodule : fsf_status_bank

// >>> test/fsf_host_model.sv
// host flash controller model: reads status, issues clear transactions
// assumes one MCLK domain and a slave that never stalls
module fsf_host_model
    import fsf_pkg::*;
(
    // bus to the status bank
    input  wire logic                       MCLK,
    input  wire logic [fsf_pkg::DATA_W-1:0] RDATA,
    output logic      [fsf_pkg::ADDR_W-1:0] ADDR,
    output logic      [fsf_pkg::DATA_W-1:0] WDATA,
    output logic                            WR,
    output logic                            RD
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        ADDR  = '0;
        WDATA = '0;
        WR    = 1'b0;
        RD    = 1'b0;
    end

    // status writes always carry the reserved defaults
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        v = d;
        if (a == OFS_STATUS) begin
            v[BIT_RESV_HI_MSB:BIT_RESV_LO] = {RESV_HI_DEFAULT,
                                              RESV_LO_DEFAULT};
        end
        @(posedge MCLK);
        WR    <= 1'b1;
        ADDR  <= a;
        WDATA <= v;
        @(posedge MCLK);
        WR    <= 1'b0;
    endtask : wr

    // data stands one cycle only, taken at the edge that closes it
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge MCLK);
        RD   <= 1'b1;
        ADDR <= a;
        @(posedge MCLK);
        RD   <= 1'b0;
        @(posedge MCLK);
        d = RDATA;
    endtask : rd

    // busy alone is not enough: both error flags looked at
    task automatic ready(output logic ok);
        logic [31:0] s;
        logic [31:0] p;
        rd(OFS_STATUS, s);
        rd(OFS_PROG_ERR, p);
        ok = !s[7] && !s[5] && !p[0];
    endtask : ready
endmodule : fsf_host_model

// >>> test/fsf_status_bank_tb.sv
// self-checking bench for the flash status flag bank
// assumes the host model drives the bus; bench drives device state
module fsf_status_bank_tb;
    import fsf_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic           MCLK;
    logic           RESETN;
    logic [7:0]     ADDR;
    logic [31:0]    WDATA;
    logic           WR;
    logic           RD;
    logic [31:0]    RDATA;
    fsf_dev_state_t DEV_STATE;
    fsf_dev_event_t DEV_EVENT;
    logic [15:0]    STATUS_WORD;
    logic           IRQ;
    int             failures;
    int             tests_run;
    int             cycles;
    logic [31:0]    d;
    logic           ok;

    fsf_status_bank i_dut (.MCLK(MCLK), .RESETN(RESETN), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .DEV_STATE(DEV_STATE), .DEV_EVENT(DEV_EVENT),
        .STATUS_WORD(STATUS_WORD), .IRQ(IRQ));

    fsf_host_model i_host (.MCLK(MCLK), .RDATA(RDATA), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD));

    initial begin
        MCLK = 1'b0;
        forever #2 MCLK = ~MCLK;
    end

    task automatic final_report;
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    // hang guard, far above the 150 or so cycles needed
    always @(posedge MCLK) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("unexpected t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // read a register and compare
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        i_host.rd(a, d);
        chk(d, exp);
    endtask : rchk

    function automatic logic [31:0] sw(input logic [3:0] f);
        return {16'h0, 6'h3f, 1'b0, f, 5'h0};
    endfunction : sw

    task automatic ev(input fsf_dev_event_t e);
        @(posedge MCLK);
        DEV_EVENT <= e;
        @(posedge MCLK);
        DEV_EVENT <= '0;
    endtask : ev

    initial begin
        RESETN    = 1'b0;
        DEV_STATE = '0;
        DEV_EVENT = '0;
        failures  = 0;
        tests_run = 0;
        cycles    = 0;
        repeat (5) @(posedge MCLK);
        RESETN <= 1'b1;
        rchk(OFS_STATUS, sw(4'h0));
        rchk(OFS_IRQ_EN, 32'h0);
        rchk(8'h20, 32'h0);
        // fields crc, busy, erase suspend in every combination
        for (int i = 0; i < 8; i++) begin
            @(posedge MCLK) DEV_STATE <= 3'(i);
            rchk(OFS_STATUS, sw({i[0], i[2], i[1], 1'b0}));
        end
        @(posedge MCLK) DEV_STATE <= '0;
        i_host.wr(OFS_STATUS, 32'hffff);
        rchk(OFS_STATUS, sw(4'h0));
        i_host.wr(OFS_IRQ_EN, 32'h7);
        rchk(OFS_IRQ_EN, 32'h7);
        i_host.wr(OFS_IRQ_CLEAR, 32'h7);
        rchk(OFS_IRQ_STAT, 32'h0);
        chk({31'h0, IRQ}, 32'h0);
        ev(5'b10000);
        rchk(OFS_STATUS, sw(4'h5));
        rchk(OFS_IRQ_STAT, 32'h1);
        chk({31'h0, IRQ}, 32'h1);
        repeat (10) @(posedge MCLK);
        i_host.wr(OFS_CLEAR_STAT, 32'h0);
        rchk(OFS_STATUS, sw(4'h5));
        i_host.ready(ok);
        chk({31'h0, ok}, 32'h0);
        i_host.wr(OFS_CLEAR_STAT, 32'h1);
        rchk(OFS_STATUS, sw(4'h0));
        rchk(OFS_IRQ_STAT, 32'h5);
        i_host.ready(ok);
        chk({31'h0, ok}, 32'h1);
        ev(5'b01000);
        rchk(OFS_STATUS, sw(4'h5));
        ev(5'b00010);
        rchk(OFS_STATUS, sw(4'h0));
        i_host.wr(OFS_IRQ_EN, 32'h0);
        i_host.wr(OFS_IRQ_CLEAR, 32'h7);
        ev(5'b00100);
        rchk(OFS_STATUS, sw(4'h4));
        rchk(OFS_PROG_ERR, 32'h1);
        chk({31'h0, IRQ}, 32'h0);
        rchk(OFS_IRQ_STAT, 32'h2);
        ev(5'b00001);
        rchk(OFS_STATUS, sw(4'h0));
        rchk(OFS_PROG_ERR, 32'h0);
        // failures and clear in one cycle: the failures win
        ev(5'b10110);
        @(posedge MCLK);
        chk({16'h0, STATUS_WORD}, sw(4'h5));
        rchk(OFS_PROG_ERR, 32'h1);
        // mid-run hardware reset drops both error flags
        @(posedge MCLK) RESETN <= 1'b0;
        @(posedge MCLK);
        chk({16'h0, STATUS_WORD}, {16'h0, STATUS_RESET});
        chk(RDATA, 32'h0);
        chk({31'h0, IRQ}, 32'h0);
        @(posedge MCLK) RESETN <= 1'b1;
        rchk(OFS_STATUS, sw(4'h0));
        rchk(OFS_PROG_ERR, 32'h0);
        chk({16'h0, STATUS_WORD}, sw(4'h0));
        final_report();
    end
endmodule : fsf_status_bank_tb
